// ---- verif/host_model.sv ----
`default_nettype none
module host_model (
  input  wire logic        clock,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_rvalid,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  output logic             page,
  output logic             commit_pending_settings
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cmd_wr, cmd_rd, cmd_code, cmd_wdata, page, commit_pending_settings} = '0;
  // one strobe carries a whole 16-bit word; byte pairing is done upstream
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
    @(posedge clock);
    cmd_wr <= w;
    cmd_rd <= !w;
    cmd_code <= c;
    cmd_wdata <= d;
    page <= p;
    @(posedge clock);
    {cmd_wr, cmd_rd} <= 2'b00;
    cmd_wdata <= ~d; // released bus must not echo the word
  endtask : access
  task automatic rd(input logic [7:0] c, input logic p, output logic [15:0] q);
    access(1'b0, c, 16'h0000, p);
    // sample mid-cycle while the answer stands; a missing answer fails the caller's compare
    @(negedge clock);
    q = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hXXXX;
  endtask : rd
  task automatic apply;
    @(posedge clock);
    commit_pending_settings <= 1'b1;
    @(posedge clock);
    commit_pending_settings <= 1'b0;
  endtask : apply
endmodule : host_model
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb;
  import vlimit_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, arst_n, cmd_wr, cmd_rd, page, commit_pending_settings, cmd_rvalid, cmd_unsupported;
  logic [7:0]       cmd_code;
  logic [15:0]      cmd_wdata, cmd_rdata, q;
  logic [1:0][1:0]  op_sel;
  logic [1:0][15:0] nominal, margin_high;
  logic [1:0]       ramping, enabled;
  reg_ctrl_t [1:0]  ctrl;
  int n_mismatch = 0;
  int n_checks = 0;
  localparam logic [7:0]  CODES [6] = '{8'h26, 8'h27, 8'h28, 8'h2B, 8'h40, 8'h44};
  localparam logic [15:0] DEFS [6] = '{16'h00FA, 16'h0064, 16'h0000, 16'h0000, 16'h076C, 16'h0000};
  host_model host (.clock, .cmd_rdata, .cmd_rvalid, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .page,
    .commit_pending_settings);
  output_voltage_limit_settings #(.PAGES(2)) uut (.clock, .arst_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .page,
    .commit_pending_settings, .op_sel, .nominal_target_mv(nominal), .margin_high_mv(margin_high),
    .output_ramping(ramping), .output_enabled(enabled), .cmd_rdata, .cmd_rvalid, .cmd_unsupported, .ctrl);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle; // ctrl follows a write or commit two edges later, other inputs one edge later
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic t_defaults;
    for (int p = 0; p < 2; p++) for (int i = 0; i < 6; i++) begin
      host.rd(CODES[i], p[0], q);
      chk(q, DEFS[i]);
    end
    $display("t_defaults done");
  endtask : t_defaults
  task automatic t_commit;
    host.access(1'b1, CMD_SLEW_RATE, 16'h03E8, 1'b0);
    host.access(1'b1, CMD_LOAD_LINE, 16'h0640, 1'b0);
    host.access(1'b1, CMD_OV_THRESHOLD, 16'h0800, 1'b0);
    settle();
    chk(ctrl[0].slew_rate, 16'h0064);
    chk(ctrl[0].ov_threshold, 16'h076C);
    host.rd(CMD_SLEW_RATE, 1'b0, q);
    chk(q, 16'h03E8);
    host.apply();
    settle();
    chk(ctrl[0].slew_rate, 16'h03E8);
    chk(ctrl[0].load_line_gain, 16'h0640);
    chk(ctrl[0].ov_threshold, 16'h0800);
    chk(ctrl[1].slew_rate, 16'h0064);
    $display("t_commit done");
  endtask : t_commit
  task automatic t_target;
    @(posedge clock);
    op_sel[0] <= OP_MARGIN_LOW;
    host.access(1'b1, CMD_MARGIN_LOW, 16'h1234, 1'b0);
    host.access(1'b1, CMD_TARGET_FLOOR, 16'h2000, 1'b0);
    settle();
    chk(ctrl[0].target_mv, 16'h2000);
    host.access(1'b1, CMD_TARGET_FLOOR, 16'h0100, 1'b0);
    settle();
    chk(ctrl[0].target_mv, 16'h1234);
    @(posedge clock);
    op_sel[0] <= OP_NOMINAL;
    settle();
    chk(ctrl[0].target_mv, 16'h0100);
    @(posedge clock);
    op_sel[0]      <= OP_MARGIN_HIGH;
    margin_high[0] <= 16'h0200;
    settle();
    chk(ctrl[0].target_mv, 16'h0200);
    $display("t_target done");
  endtask : t_target
  task automatic t_uv;
    @(posedge clock);
    enabled <= 2'b11;
    ramping <= 2'b01;
    host.access(1'b1, CMD_UV_THRESHOLD, 16'h0300, 1'b0);
    #1;
    chk(16'(cmd_unsupported), 16'h0000);
    host.access(1'b1, 8'h30, 16'h5555, 1'b0); // unknown code is not stored and raises cmd_unsupported
    #1;
    chk(16'(cmd_unsupported), 16'h0001);
    settle();
    chk(16'({ctrl[1].uv_fault_enable, ctrl[0].uv_fault_enable}), 16'h0002);
    chk(ctrl[0].uv_threshold, 16'h0300);
    @(posedge clock);
    ramping <= 2'b00;
    settle();
    chk(16'({ctrl[1].uv_fault_enable, ctrl[0].uv_fault_enable}), 16'h0003);
    @(posedge clock);
    enabled <= 2'b10;
    settle();
    chk(16'({ctrl[1].uv_fault_enable, ctrl[0].uv_fault_enable}), 16'h0002);
    $display("t_uv done");
  endtask : t_uv
  task automatic t_reset;
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk(ctrl[0].slew_rate, RST_SLEW_RATE);
    chk(ctrl[0].ov_threshold, RST_OV_THRESHOLD);
    for (int i = 0; i < 6; i++) begin
      host.rd(CODES[i], 1'b0, q);
      chk(q, DEFS[i]);
    end
    $display("t_reset done");
  endtask : t_reset
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    arst_n = 1'b0;
    op_sel = '0;
    nominal = {16'h0000, 16'h0050};
    margin_high = '0;
    ramping = '0;
    enabled = '0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    t_defaults();
    t_commit();
    t_target();
    t_uv();
    t_reset();
    print_verdict();
  end
endmodule : tb
`default_nettype wire

// ---- verif/vlimit_assertions.sv ----
`default_nettype none
module vlimit_assertions
  import vlimit_pkg::*;
#(parameter int PAGES = 2) (
  input wire logic                        clock,
  input wire logic                        arst_n,
  input wire logic                        cmd_wr,
  input wire logic                        cmd_rd,
  input wire logic [7:0]                  cmd_code,
  input wire logic [$clog2(PAGES)-1:0]    page,
  input wire logic                        commit_pending_settings,
  input wire logic [PAGES-1:0]            output_ramping,
  input wire logic [PAGES-1:0]            output_enabled,
  input wire logic [15:0]                 cmd_rdata,
  input wire logic                        cmd_rvalid,
  input wire logic                        cmd_unsupported,
  input wire vlimit_pkg::reg_ctrl_t [PAGES-1:0] ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic known = cmd_code inside {CMD_MARGIN_LOW, CMD_SLEW_RATE, CMD_LOAD_LINE,
                                      CMD_TARGET_FLOOR, CMD_OV_THRESHOLD, CMD_UV_THRESHOLD};
  a_read_answer: assert property (cmd_rd |=> cmd_rvalid) else $error("read not answered");
  a_idle_quiet: assert property (!cmd_rd |=> !cmd_rvalid && cmd_rdata == 16'h0000) else $error("idle read data");
  a_bad_code: assert property ((cmd_wr || cmd_rd) && !known |=> cmd_unsupported) else $error("bad code");
  a_good_code: assert property ((cmd_wr || cmd_rd) && known |=> !cmd_unsupported) else $error("good code");
  a_commit_gate: assert property ($changed({ctrl[0].slew_rate, ctrl[0].load_line_gain, ctrl[0].ov_threshold})
    |-> $past(commit_pending_settings, 2)) else $error("staged value applied early");
  a_uv_masked: assert property (output_ramping[0] || !output_enabled[0] |=> !ctrl[0].uv_fault_enable)
    else $error("uv fault not masked");
  a_uv_armed: assert property (output_enabled[0] && !output_ramping[0] |=> ctrl[0].uv_fault_enable)
    else $error("uv fault not armed");
  a_uv_limit: assert property ($changed(ctrl[0].uv_threshold)
    |-> $past(cmd_wr && cmd_code == CMD_UV_THRESHOLD && page == '0, 2)) else $error("uv limit moved");
  c_commit: cover property (commit_pending_settings ##2 $changed(ctrl[0].slew_rate));
  c_unsup: cover property (cmd_unsupported);
  c_uv_mask: cover property ($fell(ctrl[0].uv_fault_enable));
endmodule : vlimit_assertions
bind output_voltage_limit_settings vlimit_assertions #(.PAGES(PAGES)) chk (.clock, .arst_n, .cmd_wr, .cmd_rd,
  .cmd_code, .page, .commit_pending_settings, .output_ramping, .output_enabled, .cmd_rdata, .cmd_rvalid,
  .cmd_unsupported, .ctrl);
`default_nettype wire

// ---- verilog/output_voltage_limit_settings.sv ----
`default_nettype none
module output_voltage_limit_settings
  import vlimit_pkg::*;
#(
  parameter int PAGES = 2
) (
  input  wire logic                         clock,
  input  wire logic                         arst_n,
  input  wire logic                         cmd_wr,
  input  wire logic                         cmd_rd,
  input  wire logic [7:0]                   cmd_code,
  input  wire logic [15:0]                  cmd_wdata,
  input  wire logic [$clog2(PAGES)-1:0]     page,
  input  wire logic                         commit_pending_settings,
  input  wire logic [PAGES-1:0][1:0]        op_sel,
  input  wire logic [PAGES-1:0][15:0]       nominal_target_mv,
  input  wire logic [PAGES-1:0][15:0]       margin_high_mv,
  input  wire logic [PAGES-1:0]             output_ramping,
  input  wire logic [PAGES-1:0]             output_enabled,
  output logic [15:0]                       cmd_rdata,
  output logic                              cmd_rvalid,
  output logic                              cmd_unsupported,
  output vlimit_pkg::reg_ctrl_t [PAGES-1:0] ctrl
);
  // ==========================================================================
  // per-page banks
  logic [PAGES-1:0][15:0] page_rdata;
  logic [PAGES-1:0]       page_hit;

  genvar g;
  generate
    for (g = 0; g < PAGES; g++) begin : g_page
      logic [15:0] margin_low;
      logic [15:0] target_floor;
      logic [15:0] uv_threshold;
      logic [15:0] slew_active;
      logic [15:0] load_line_active;
      logic [15:0] ov_active;
      logic [15:0] requested;
      cmd_t        page_cmd;
      wire         selected = page == g;

      // only the addressed page sees writes
      assign page_cmd.wr    = cmd_wr && selected;
      assign page_cmd.rd    = cmd_rd && selected;
      assign page_cmd.code  = cmd_code;
      assign page_cmd.wdata = cmd_wdata;

      page_settings u_bank (
        .clock            (clock),
        .arst_n           (arst_n),
        .cmd              (page_cmd),
        .commit           (commit_pending_settings),
        .rdata            (page_rdata[g]),
        .hit              (page_hit[g]),
        .margin_low       (margin_low),
        .target_floor     (target_floor),
        .uv_threshold     (uv_threshold),
        .slew_active      (slew_active),
        .load_line_active (load_line_active),
        .ov_active        (ov_active)
      );

      // target select; the floor is applied last so nothing can go under it
      assign requested = (op_sel[g] == OP_MARGIN_LOW)  ? margin_low :
                         (op_sel[g] == OP_MARGIN_HIGH) ? margin_high_mv[g] :
                         nominal_target_mv[g];

      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          ctrl[g] <= '{target_mv: RST_TARGET_FLOOR, slew_rate: RST_SLEW_RATE,
                       load_line_gain: RST_LOAD_LINE, ov_threshold: RST_OV_THRESHOLD,
                       uv_threshold: RST_UV_THRESHOLD, uv_fault_enable: 1'b0};
        end else begin
          ctrl[g].target_mv       <= (requested < target_floor) ? target_floor : requested;
          ctrl[g].slew_rate       <= slew_active;
          ctrl[g].load_line_gain  <= load_line_active;
          ctrl[g].ov_threshold    <= ov_active;
          ctrl[g].uv_threshold    <= uv_threshold;
          ctrl[g].uv_fault_enable <= output_enabled[g] && !output_ramping[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read return, registered one cycle after the request
  wire [15:0] sel_rdata = page_rdata[page];
  wire        sel_hit   = page_hit[page];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_rdata       <= 16'h0000;
      cmd_rvalid      <= 1'b0;
      cmd_unsupported <= 1'b0;
    end else begin
      cmd_rvalid      <= cmd_rd;
      cmd_rdata       <= cmd_rd ? sel_rdata : 16'h0000;
      cmd_unsupported <= (cmd_rd || cmd_wr) && !sel_hit;
    end
  end
endmodule : output_voltage_limit_settings
`default_nettype wire

// ---- verilog/page_settings.sv ----
`default_nettype none
module page_settings
  import vlimit_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire vlimit_pkg::cmd_t   cmd,
  input  wire logic               commit,
  output logic [15:0]             rdata,
  output logic                    hit,
  output logic [15:0]             margin_low,
  output logic [15:0]             target_floor,
  output logic [15:0]             uv_threshold,
  output logic [15:0]             slew_active,
  output logic [15:0]             load_line_active,
  output logic [15:0]             ov_active
);
  // ==========================================================================
  // staged values, as read back by the host
  logic [15:0] slew_stage;
  logic [15:0] load_line_stage;
  logic [15:0] ov_stage;

  wire wr_margin = cmd.wr && cmd.code == CMD_MARGIN_LOW;
  wire wr_slew   = cmd.wr && cmd.code == CMD_SLEW_RATE;
  wire wr_load   = cmd.wr && cmd.code == CMD_LOAD_LINE;
  wire wr_floor  = cmd.wr && cmd.code == CMD_TARGET_FLOOR;
  wire wr_ov     = cmd.wr && cmd.code == CMD_OV_THRESHOLD;
  wire wr_uv     = cmd.wr && cmd.code == CMD_UV_THRESHOLD;

  // ==========================================================================
  // storage, full 16-bit words per page
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      margin_low      <= RST_MARGIN_LOW;
      slew_stage      <= RST_SLEW_RATE;
      load_line_stage <= RST_LOAD_LINE;
      target_floor    <= RST_TARGET_FLOOR;
      ov_stage        <= RST_OV_THRESHOLD;
      uv_threshold    <= RST_UV_THRESHOLD;
    end else begin
      if (wr_margin) margin_low <= cmd.wdata;
      if (wr_slew)   slew_stage <= cmd.wdata;
      if (wr_load)   load_line_stage <= cmd.wdata;
      if (wr_floor)  target_floor <= cmd.wdata;
      if (wr_ov)     ov_stage <= cmd.wdata;
      if (wr_uv)     uv_threshold <= cmd.wdata;
    end
  end

  // ==========================================================================
  // active copies move only on commit; a write in the commit cycle waits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slew_active      <= RST_SLEW_RATE;
      load_line_active <= RST_LOAD_LINE;
      ov_active        <= RST_OV_THRESHOLD;
    end else if (commit) begin
      slew_active      <= slew_stage;
      load_line_active <= load_line_stage;
      ov_active        <= ov_stage;
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    hit = 1'b1;
    unique case (cmd.code)
      CMD_MARGIN_LOW:   rdata = margin_low;
      CMD_SLEW_RATE:    rdata = slew_stage;
      CMD_LOAD_LINE:    rdata = load_line_stage;
      CMD_TARGET_FLOOR: rdata = target_floor;
      CMD_OV_THRESHOLD: rdata = ov_stage;
      CMD_UV_THRESHOLD: rdata = uv_threshold;
      default: begin
        rdata = 16'h0000;
        hit   = 1'b0;
      end
    endcase
  end
endmodule : page_settings
`default_nettype wire

// ---- verilog/vlimit_pkg.sv ----
`default_nettype none
package vlimit_pkg;
  // ==========================================================================
  // command codes
  localparam logic [7:0]  CMD_MARGIN_LOW    = 8'h26;
  localparam logic [7:0]  CMD_SLEW_RATE     = 8'h27;
  localparam logic [7:0]  CMD_LOAD_LINE     = 8'h28;
  localparam logic [7:0]  CMD_TARGET_FLOOR  = 8'h2B;
  localparam logic [7:0]  CMD_OV_THRESHOLD  = 8'h40;
  localparam logic [7:0]  CMD_UV_THRESHOLD  = 8'h44;
  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_MARGIN_LOW    = 16'h00FA;
  localparam logic [15:0] RST_SLEW_RATE     = 16'h0064;
  localparam logic [15:0] RST_LOAD_LINE     = 16'h0000;
  localparam logic [15:0] RST_TARGET_FLOOR  = 16'h0000;
  localparam logic [15:0] RST_OV_THRESHOLD  = 16'h076C;
  localparam logic [15:0] RST_UV_THRESHOLD  = 16'h0000;
  // ==========================================================================
  // scale factors and limits of the direct format
  localparam int          SLEW_UV_PER_US_LSB = 100;
  localparam int          LOAD_LINE_UV_PER_A_LSB = 10;
  localparam logic [15:0] SLEW_RATE_MIN     = 16'h0001;
  localparam logic [15:0] SLEW_RATE_MAX     = 16'h03E8;
  localparam logic [15:0] LOAD_LINE_MAX     = 16'h0640;
  // ==========================================================================
  // operation state selecting the target
  typedef enum logic [1:0] {
    OP_NOMINAL     = 2'b00,
    OP_MARGIN_LOW  = 2'b01,
    OP_MARGIN_HIGH = 2'b10
  } op_sel_t;
  // ==========================================================================
  // settings carried to the regulation and fault logic
  typedef struct packed {
    logic [15:0] target_mv;
    logic [15:0] slew_rate;
    logic [15:0] load_line_gain;
    logic [15:0] ov_threshold;
    logic [15:0] uv_threshold;
    logic        uv_fault_enable;
  } reg_ctrl_t;
  // one register access from the command interface
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] wdata;
  } cmd_t;
endpackage : vlimit_pkg
`default_nettype wire
